// ===== hdl/ecal_defines.vh
// constants of the configuration autoloader
// ****************************************
// Function
// - valid flag at bit 15, read only for the host
// - valid flag cleared by hardware reset or a failed read, not soft reset or stop
// - automatic image read starts after hardware reset releases
// - valid set only if prom answered and 36-byte checksum correct
// - valid zero after any read restores loadable registers to defaults
// - absent prom ends read early, valid stays zero
// - host writes one to bit 14 to reload 36 bytes
// - each fetched byte lands in its configuration register
// - host reads return internal copy, no prom access
// - host writes change internal copy only, never the prom
// - reload command bit self clears when commanded read ends
// - host accesses ignored while commanded read in progress
// - absent prom on command: clear bit, valid zero, relocatable mode
// - bits 31-16 written zero by host, read back as zero
// - strap says no prom: skip auto read, enter relocatable mode
// - command bit writable only while stop is one; hardware reset clears
// ****************************************
`ifndef ECAL_DEFINES_VH
`define ECAL_DEFINES_VH
`define ECAL_OFS_STATION 8'h00
`define ECAL_OFS_CFG0 8'h10
`define ECAL_OFS_CTRL 8'h4C
`define ECAL_OFS_CMD 8'h50
`define ECAL_OFS_IRQ_STAT 8'h54
`define ECAL_OFS_IRQ_MASK 8'h58
`define ECAL_BIT_VALID 15
`define ECAL_BIT_RELOAD 14
`define ECAL_BIT_DETECT 3
`define ECAL_BIT_STOP 0
`define ECAL_BIT_RELOC 1
`define ECAL_IMG_BYTES 36
`define ECAL_SK_HALF 4
`define ECAL_CMD_READ 3'h6
`define ECAL_ADDR_BITS 6
`define ECAL_ABSENT_CLKS 2
`define ECAL_CHECK_VAL 8'hFF
`define ECAL_IRQ_DONE 0
`define ECAL_IRQ_FAIL 1
`endif

// ===== hdl/ecal_shifter.v
// serial prom bit engine: one clock, one sample per bit
`timescale 1ns/100ps
module ecal_shifter (
    input wire ref_clk,
    input wire nrst,
    input wire start,
    input wire dout_bit,
    input wire din_sync,
    output reg sk_ff,
    output reg bit_done_ff,
    output reg sample_ff
);
`include "ecal_defines.vh"
reg [3:0] cnt_ff;
reg busy_ff;
// ****************************************
// serial clock from bus clock
// ****************************************
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        cnt_ff <= 4'h0;
        busy_ff <= 1'b0;
        sk_ff <= 1'b0;
        bit_done_ff <= 1'b0;
        sample_ff <= 1'b0;
    end else begin
        bit_done_ff <= 1'b0;
        if (start && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff <= 4'h0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == `ECAL_SK_HALF - 1) begin
                sk_ff <= 1'b1;
                sample_ff <= din_sync;
            end
            if (cnt_ff == 2 * `ECAL_SK_HALF - 1) begin
                sk_ff <= 1'b0;
                busy_ff <= 1'b0;
                bit_done_ff <= 1'b1;
            end
        end
    end
end
endmodule // ecal_shifter

// ===== hdl/ecal_top.v
// configuration autoloader with ahb-lite register slave
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module ecal_top (
    input wire ref_clk,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output wire irq,
    input wire eeprom_detect_strap_pin,
    input wire serial_prom_data_in_pin,
    output reg serial_prom_cs_ff,
    output wire serial_prom_clock_pin,
    output reg serial_prom_data_out_pin
);
`include "ecal_defines.vh"
localparam ST_IDLE = 3'h0;
localparam ST_CMD = 3'h1;
localparam ST_DATA = 3'h2;
localparam ST_GAP = 3'h3;
localparam ST_END = 3'h4;
localparam CMD_BITS = 3 + `ECAL_ADDR_BITS;
localparam [31:0] IMG_LAST = `ECAL_IMG_BYTES - 1;
localparam [6:0] LAST_BYTE = IMG_LAST[6:0];
// ****************************************
// pin synchronisers
// ****************************************
reg [1:0] din_sync_ff;
reg [1:0] strap_sync_ff;
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        din_sync_ff <= 2'h0;
    end else begin
        din_sync_ff <= {din_sync_ff[0], serial_prom_data_in_pin};
    end
end
// strap sync runs through reset so its level is settled at release
always @(posedge ref_clk) begin
    strap_sync_ff <= {strap_sync_ff[0], eeprom_detect_strap_pin};
end
// ****************************************
// state and registers
// ****************************************
reg [2:0] state_ff;
reg [3:0] bitcnt_ff;
reg [6:0] byte_ff;
reg [7:0] shreg_ff;
reg [7:0] sum_ff;
reg [CMD_BITS-1:0] cmdsh_ff;
reg valid_ff;
reg reload_ff;
reg stop_ff;
reg reloc_ff;
reg detect_ff;
reg boot_ff;
reg auto_ff;
reg answered_ff;
reg [1:0] irq_stat_ff;
reg [1:0] irq_mask_ff;
reg [7:0] img_ff [0:`ECAL_IMG_BYTES-1];
reg go_ff;
wire bit_done;
wire sample;
wire sk;
wire busy = (state_ff != ST_IDLE);
wire cmd_busy = busy && !auto_ff;
ecal_shifter u_shift (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(go_ff),
    .dout_bit(serial_prom_data_out_pin),
    .din_sync(din_sync_ff[1]),
    .sk_ff(sk),
    .bit_done_ff(bit_done),
    .sample_ff(sample)
);
assign serial_prom_clock_pin = sk;
// ****************************************
// ahb-lite slave
// ****************************************
reg ap_wr_ff;
reg [7:0] ap_addr_ff;
reg [31:0] rdata_ff;
wire ap_take = hsel && hready && htrans[1];
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = rdata_ff;
assign irq = |(irq_stat_ff & irq_mask_ff);
// accesses are dropped while a commanded read runs
wire acc_ok = !cmd_busy;
wire wr_en = ap_wr_ff && acc_ok;
wire [31:0] ctrl_word = {16'h0000, valid_ff, reload_ff, 10'h000, detect_ff, 3'h0};
// read word latched in the address phase so it stands through the data phase;
// limitation: a read right behind a write to the same word sees the old word
wire [7:0] rd_addr = haddr[7:0];
reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h0000_0000;
    if (rd_addr[1:0] == 2'h0 && rd_addr[7:2] < 6'h09)
        rd_mux = {img_ff[{rd_addr[5:2], 2'h3}], img_ff[{rd_addr[5:2], 2'h2}],
                  img_ff[{rd_addr[5:2], 2'h1}], img_ff[{rd_addr[5:2], 2'h0}]};
    else if (rd_addr == `ECAL_OFS_CTRL)
        rd_mux = ctrl_word;
    else if (rd_addr == `ECAL_OFS_CMD)
        rd_mux = {30'h0, reloc_ff, stop_ff};
    else if (rd_addr == `ECAL_OFS_IRQ_STAT)
        rd_mux = {30'h0, irq_stat_ff};
    else if (rd_addr == `ECAL_OFS_IRQ_MASK)
        rd_mux = {30'h0, irq_mask_ff};
end
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        ap_wr_ff <= 1'b0;
        ap_addr_ff <= 8'h00;
        rdata_ff <= 32'h0000_0000;
    end else begin
        ap_wr_ff <= ap_take && hwrite && acc_ok;
        if (ap_take)
            ap_addr_ff <= haddr[7:0];
        if (ap_take && !hwrite)
            rdata_ff <= acc_ok ? rd_mux : 32'h0000_0000;
    end
end
// ****************************************
// image store: defaults are zero
// ****************************************
wire store_byte = (state_ff == ST_DATA) && bit_done && (bitcnt_ff == 4'h7);
wire [7:0] new_byte = {shreg_ff[6:0], sample};
wire fail_end = (state_ff == ST_END) && !(answered_ff && sum_ff == `ECAL_CHECK_VAL);
genvar gi;
generate
    for (gi = 0; gi < `ECAL_IMG_BYTES; gi = gi + 1) begin : g_img
        always @(posedge ref_clk or negedge nrst) begin
            if (!nrst)
                img_ff[gi] <= 8'h00;
            else if (fail_end)
                img_ff[gi] <= 8'h00;
            else if (store_byte && byte_ff == gi)
                img_ff[gi] <= new_byte;
            else if (wr_en && ap_addr_ff[7:2] == gi / 4 && gi / 4 < 9)
                img_ff[gi] <= hwdata[8*(gi%4)+:8];
        end
    end
endgenerate
// ****************************************
// sequencer
// ****************************************
wire ctrl_wr = wr_en && (ap_addr_ff == `ECAL_OFS_CTRL);
wire cmd_wr = wr_en && (ap_addr_ff == `ECAL_OFS_CMD);
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        state_ff <= ST_IDLE;
        bitcnt_ff <= 4'h0;
        byte_ff <= 7'h00;
        shreg_ff <= 8'h00;
        sum_ff <= 8'h00;
        cmdsh_ff <= {CMD_BITS{1'b0}};
        valid_ff <= 1'b0;
        reload_ff <= 1'b0;
        stop_ff <= 1'b1;
        reloc_ff <= 1'b0;
        detect_ff <= 1'b0;
        boot_ff <= 1'b1;
        auto_ff <= 1'b0;
        answered_ff <= 1'b0;
        irq_stat_ff <= 2'h0;
        irq_mask_ff <= 2'h0;
        go_ff <= 1'b0;
        serial_prom_cs_ff <= 1'b0;
        serial_prom_data_out_pin <= 1'b0;
    end else begin
        go_ff <= 1'b0;
        if (cmd_wr) begin
            stop_ff <= hwdata[`ECAL_BIT_STOP];
            if (hwdata[`ECAL_BIT_RELOC])
                reloc_ff <= 1'b0;
        end
        if (wr_en && ap_addr_ff == `ECAL_OFS_IRQ_MASK)
            irq_mask_ff <= hwdata[1:0];
        if (wr_en && ap_addr_ff == `ECAL_OFS_IRQ_STAT)
            irq_stat_ff <= irq_stat_ff & ~hwdata[1:0];
        case (state_ff)
        ST_IDLE: begin
            if (boot_ff) begin
                boot_ff <= 1'b0;
                detect_ff <= strap_sync_ff[1];
                if (strap_sync_ff[1]) begin
                    auto_ff <= 1'b1;
                    state_ff <= ST_CMD;
                end else begin
                    reloc_ff <= 1'b1;
                end
            end else if (ctrl_wr && stop_ff && hwdata[`ECAL_BIT_RELOAD]) begin
                reload_ff <= 1'b1;
                auto_ff <= 1'b0;
                state_ff <= ST_CMD;
            end
            if (boot_ff && strap_sync_ff[1] || ctrl_wr && stop_ff && hwdata[`ECAL_BIT_RELOAD]) begin
                cmdsh_ff <= {`ECAL_CMD_READ, {`ECAL_ADDR_BITS{1'b0}}};
                bitcnt_ff <= 4'h0;
                byte_ff <= 7'h00;
                sum_ff <= 8'h00;
                answered_ff <= 1'b0;
                serial_prom_cs_ff <= 1'b1;
                go_ff <= 1'b1;
            end
        end
        ST_CMD: begin
            serial_prom_data_out_pin <= cmdsh_ff[CMD_BITS-1];
            if (bit_done) begin
                cmdsh_ff <= {cmdsh_ff[CMD_BITS-2:0], 1'b0};
                bitcnt_ff <= bitcnt_ff + 4'h1;
                // commanded reads are never cut short at two clocks, whatever the strap said
                if (auto_ff && !detect_ff && bitcnt_ff == `ECAL_ABSENT_CLKS - 1) begin
                    state_ff <= ST_END; // cut short after two clocks
                end else if (bitcnt_ff == CMD_BITS) begin
                    // dummy zero from prom, one clock after the address, marks presence
                    answered_ff <= !sample;
                    bitcnt_ff <= 4'h0;
                    state_ff <= sample ? ST_END : ST_GAP;
                end else
                    go_ff <= 1'b1;
            end
        end
        ST_DATA: begin
            serial_prom_data_out_pin <= 1'b0;
            if (bit_done) begin
                shreg_ff <= new_byte;
                bitcnt_ff <= bitcnt_ff + 4'h1;
                if (bitcnt_ff == 4'h7) begin
                    bitcnt_ff <= 4'h0;
                    sum_ff <= sum_ff + new_byte;
                    byte_ff <= byte_ff + 7'h01;
                    state_ff <= (byte_ff == LAST_BYTE) ? ST_END : ST_GAP;
                end else
                    go_ff <= 1'b1;
            end
        end
        ST_GAP: begin
            go_ff <= 1'b1;
            state_ff <= ST_DATA;
        end
        ST_END: begin
            serial_prom_cs_ff <= 1'b0;
            valid_ff <= answered_ff && (sum_ff == `ECAL_CHECK_VAL);
            reload_ff <= 1'b0;
            if (!answered_ff)
                reloc_ff <= 1'b1;
            irq_stat_ff[`ECAL_IRQ_DONE] <= 1'b1;
            if (!(answered_ff && sum_ff == `ECAL_CHECK_VAL))
                irq_stat_ff[`ECAL_IRQ_FAIL] <= 1'b1;
            auto_ff <= 1'b0;
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
        endcase
    end
end
endmodule // ecal_top

// ===== sim/ecal_monitor.sv
// port checks of the configuration autoloader
`timescale 1ns/100ps
module ecal_monitor (
    input wire ref_clk,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire serial_prom_cs_ff,
    input wire serial_prom_clock_pin,
    input wire serial_prom_data_out_pin
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire take = hsel & hready & htrans[1];
    reg rd_ctrl_ff;
    reg [9:0] rise_cnt_ff;
    // ****************
    // helper flag and counter
    // ****************
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_ctrl_ff <= 1'b0;
            rise_cnt_ff <= 10'h000;
        end else begin
            rd_ctrl_ff <= take & !hwrite & (haddr == 32'h0000004C);
            if (!serial_prom_cs_ff)
                rise_cnt_ff <= 10'h000;
            else if ($rose(serial_prom_clock_pin))
                rise_cnt_ff <= rise_cnt_ff + 10'h001;
        end
    end
    a_okay_resp: assert property (hresp == 1'b0) else $error("bad response");
    a_zero_wait: assert property (hreadyout) else $error("wait inserted");
    a_frame_len_ok: assert property ($fell(serial_prom_cs_ff) |->
        (rise_cnt_ff == 10'h12A || rise_cnt_ff <= 10'h00A)) else $error("frame length");
    a_sk_period: assert property ($rose(serial_prom_clock_pin) |=>
        (!$rose(serial_prom_clock_pin)) [*7]) else $error("clock too fast");
    a_di_hold_sk: assert property (serial_prom_clock_pin && $past(serial_prom_clock_pin)
        |-> $stable(serial_prom_data_out_pin)) else $error("data moved at high clock");
    a_cmd_start_one: assert property ($rose(serial_prom_cs_ff) |->
        ##[0:9] serial_prom_data_out_pin) else $error("no start bit");
    a_reserved_zero: assert property (rd_ctrl_ff |-> hrdata[31:16] == 16'h0000)
        else $error("upper bits set");
    a_no_prom_touch: assert property (take && haddr < 32'h24 && !serial_prom_cs_ff
        |=> !serial_prom_cs_ff [*2]) else $error("prom touched by host");
endmodule // ecal_monitor
bind ecal_top ecal_monitor u_ecal_monitor (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_prom_cs_ff(serial_prom_cs_ff),
    .serial_prom_clock_pin(serial_prom_clock_pin),
    .serial_prom_data_out_pin(serial_prom_data_out_pin));

// ===== sim/ecal_prom_model.sv
// behavioural three-wire serial prom
`timescale 1ns/100ps
module ecal_prom_model (
    input wire cs,
    input wire sk,
    input wire di,
    output logic dout
);
    logic [7:0] mem [0:35];
    logic present = 1'b1;
    logic [8:0] cmd_sr = 9'h000;
    int cnt = 0;
    initial dout = 1'b1;
    always @(posedge sk or negedge cs) begin
        if (!cs) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
            if (cnt < 9) cmd_sr <= {cmd_sr[7:0], di};
        end
    end
    // absent part: pull-up level; released line flips so stale data never matches
    always @(negedge sk or negedge cs) begin
        if (!present) dout <= 1'b1;
        else if (!cs) dout <= ~dout;
        else if (cnt == 9) dout <= 1'b0;
        else if (cnt > 9 && cnt < 298) dout <= mem[(cnt-10)/8][7-((cnt-10)%8)];
    end
endmodule // ecal_prom_model

// ===== sim/ecal_top_tb.sv
// self-checking bench of the configuration autoloader
`timescale 1ns/100ps
module ecal_top_tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic strap = 1'b1;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, cs, sk, dout, din;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h49A6;
    logic [7:0] img [0:35];
    logic [31:0] r;
    always #4 ref_clk = ~ref_clk;
    ecal_top u_ecal_top (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .eeprom_detect_strap_pin(strap), .serial_prom_data_in_pin(din),
        .serial_prom_cs_ff(cs), .serial_prom_clock_pin(sk), .serial_prom_data_out_pin(dout));
    ecal_prom_model u_ecal_prom_model (.cs(cs), .sk(sk), .di(dout), .dout(din));
    // ****************
    // helpers
    // ****************
    function logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one single transfer; the wait ends only by the bench timeout
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task frame;
        int n;
        n = 0;
        while (cs !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        while (cs !== 1'b0) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
    endtask
    task load_img(input logic good);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 36; i++) begin
            seed = xs(seed);
            img[i] = seed[7:0];
            if (i < 35) sum = sum + img[i];
        end
        img[35] = 8'hFF - sum + {7'h00, !good};
        for (int i = 0; i < 36; i++) u_ecal_prom_model.mem[i] = img[i];
    endtask
    task chk_img(input logic good);
        for (int k = 0; k < 9; k++) begin
            bus(1'b0, 8'(4*k), 32'h0);
            chk(r, good ? {img[4*k+3], img[4*k+2], img[4*k+1], img[4*k]} : 32'h0, "image");
        end
    endtask
    task reset_dut(input logic s);
        strap <= s;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
    endtask
    task reload;
        bus(1'b1, 8'h4C, 32'h00004000);
        frame;
        bus(1'b0, 8'h4C, 32'h0);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("wrong value at %0t: timeout", $time);
            tally_and_finish;
        end
    end
    // ****************
    // tests
    // ****************
    initial begin
        load_img(1'b1);
        reset_dut(1'b1);
        frame;
        bus(1'b0, 8'h4C, 32'h0);
        chk(r & 32'h0000C008, 32'h00008008, "auto ctrl");
        chk_img(1'b1);
        bus(1'b0, 8'h50, 32'h0);
        chk(r & 32'h3, 32'h1, "cmd reset");
        seed = xs(seed);
        bus(1'b1, 8'h10, seed);
        bus(1'b0, 8'h10, 32'h0);
        chk(r, seed, "copy");
        bus(1'b1, 8'h4C, 32'h0);
        bus(1'b0, 8'h4C, 32'h0);
        chk(r & 32'h8000, 32'h8000, "valid ro");
        $display("test auto finished");
        bus(1'b1, 8'h50, 32'h0);
        bus(1'b1, 8'h4C, 32'h00004000);
        repeat (20) @(posedge ref_clk);
        chk({31'h0, cs}, 32'h0, "stop low");
        bus(1'b0, 8'h4C, 32'h0);
        chk(r & 32'hC000, 32'h8000, "stop low ctrl");
        bus(1'b1, 8'h50, 32'h1);
        $display("test stop finished");
        load_img(1'b0);
        bus(1'b1, 8'h54, 32'h3);
        bus(1'b1, 8'h4C, 32'h00004000);
        bus(1'b1, 8'h00, seed);
        bus(1'b0, 8'h00, 32'h0);
        chk(r, 32'h0, "busy read");
        frame;
        bus(1'b0, 8'h4C, 32'h0);
        chk(r & 32'hC000, 32'h0, "bad sum");
        chk_img(1'b0);
        chk({31'h0, irq}, 32'h0, "masked");
        bus(1'b1, 8'h58, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1, "irq on");
        bus(1'b0, 8'h54, 32'h0);
        chk(r & 32'h3, 32'h3, "status");
        bus(1'b1, 8'h54, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0, "irq off");
        $display("test bad finished");
        u_ecal_prom_model.present = 1'b0;
        reload;
        chk(r & 32'hC000, 32'h0, "absent");
        bus(1'b0, 8'h50, 32'h0);
        chk(r & 32'h3, 32'h3, "reloc");
        $display("test absent finished");
        u_ecal_prom_model.present = 1'b1;
        load_img(1'b1);
        reload;
        chk(r & 32'hC000, 32'h8000, "good");
        chk_img(1'b1);
        chk({23'h0, u_ecal_prom_model.cmd_sr}, 32'h180, "command");
        bus(1'b1, 8'h50, 32'h0);
        bus(1'b1, 8'h50, 32'h1);
        bus(1'b0, 8'h4C, 32'h0);
        chk(r & 32'h8000, 32'h8000, "stop kept");
        $display("test good finished");
        reset_dut(1'b0);
        frame;
        bus(1'b0, 8'h4C, 32'h0);
        chk(r & 32'hC008, 32'h0, "strap low");
        bus(1'b0, 8'h50, 32'h0);
        chk(r & 32'h3, 32'h3, "strap reloc");
        chk_img(1'b0);
        load_img(1'b1);
        reload;
        chk(r & 32'hC008, 32'h8000, "reload no strap");
        $display("test strap finished");
        tally_and_finish;
    end
endmodule // ecal_top_tb
